// File: hdl/msvc_ctrl.sv
// Memory-select and volume switch controller
`include "msvc_defines.svh"
module msvc_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Switch pins
  input wire logic first_select_input_i,
  input wire logic second_select_input_i,
  input wire logic volume_up_input_i,
  input wire logic volume_down_input_i,
  // Configuration
  input wire msvc_pkg::ms_cfg_t ms_cfg_i,
  input wire msvc_pkg::vol_cfg_t vol_cfg_i,
  input wire logic [15:0] deb_cycles_i,
  input wire logic [7:0] analog_vol_i,
  input wire logic [7:0] trim_raw_i [`MSVC_NUM_TRIM],
  input wire logic [1:0] trim_sel_i [`MSVC_NUM_PARAM],
  // Results
  output logic [1:0] memory_o,
  output logic [4:0] volume_o,
  output logic [7:0] analog_gain_o,
  output logic vol_up_req_o,
  output logic vol_down_req_o,
  output logic [3:0] param_val_o [`MSVC_NUM_PARAM]
);
  import msvc_pkg::*;

  // ============================================================
  // Input conditioning
  localparam int NSW = 4;
  logic [NSW-1:0] raw, s1_q, s2_q, deb_q, deb_prev_q, deb_d;
  logic [NSW-1:0] closed, press;
  logic [15:0] cnt_q [NSW];
  logic [15:0] cnt_d [NSW];
  // Polarity: pullup means a closed switch reads low
  assign raw = {volume_down_input_i, volume_up_input_i,
                second_select_input_i ^ ms_cfg_i.second_polarity_setting,
                first_select_input_i ^ ms_cfg_i.first_polarity_setting};
  // Volume pins have no polarity setting: their buttons always close to battery

  genvar gi;
  generate
    for (gi = 0; gi < NSW; gi++) begin : g_deb
      // Debounce: accept a new level only after it held a full period
      always_comb begin
        cnt_d[gi] = cnt_q[gi];
        deb_d[gi] = deb_q[gi];
        if (s2_q[gi] == deb_q[gi]) begin
          cnt_d[gi] = '0;
        end else if (cnt_q[gi] >= deb_cycles_i) begin
          deb_d[gi] = s2_q[gi];
          cnt_d[gi] = '0;
        end else begin
          cnt_d[gi] = cnt_q[gi] + 16'h0001;
        end
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cnt_q[gi] <= '0;
        end else begin
          cnt_q[gi] <= cnt_d[gi];
        end
      end
    end
  endgenerate

  // Two-stage synchroniser then debounced level and edge history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      deb_q <= '0;
      deb_prev_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      deb_q <= deb_d;
      deb_prev_q <= deb_q;
    end
  end
  assign closed = deb_q;
  assign press = deb_q & ~deb_prev_q;

  // ============================================================
  // Memory selection
  sw_mode_t mode;
  logic started_q, started_d;
  logic [1:0] mem_q, mem_d, saved_q, saved_d;
  logic [1:0] dec, nxt, top;
  logic rocker_ms, in_d_q, in_d_d;

  // Mode from the two settings
  always_comb begin
    unique case ({ms_cfg_i.switch_type_setting, ms_cfg_i.dedicate_setting})
      2'b00: mode = MODE_MOM_SINGLE;
      2'b01: mode = MODE_MOM_DED;
      2'b10: mode = MODE_STAT_DUAL;
      default: mode = MODE_STAT_DED;
    endcase
  end

  // Next valid memory, wrapping to A past the highest usable one
  function automatic logic [1:0] next_mem(input logic [1:0] cur, input logic [3:0] v,
                                          input logic no_d);
    logic [1:0] c;
    logic [1:0] r;
    c = cur;
    r = `MSVC_MEM_A;
    for (int k = 0; k < 3; k++) begin
      c = c + 2'h1;
      if (c == `MSVC_MEM_A) break;
      if (v[c] && !(no_d && c == `MSVC_MEM_D) && r == `MSVC_MEM_A) begin
        r = c;
        break;
      end
    end
    return r;
  endfunction

  assign rocker_ms = vol_cfg_i.digital_vol_en & vol_cfg_i.rocker_ms_en;
  assign dec = {closed[1], closed[0]} ;
  assign top = `MSVC_MEM_D;

  // Memory update per mode
  always_comb begin
    mem_d = mem_q;
    saved_d = saved_q;
    in_d_d = in_d_q;
    started_d = 1'b1;
    nxt = next_mem(mem_q, ms_cfg_i.mem_valid | 4'h1, mode == MODE_MOM_DED);
    unique case (mode)
      MODE_MOM_SINGLE: begin
        if (press[0] || (rocker_ms && press[2])) begin
          mem_d = nxt;
        end else if (rocker_ms && press[3]) begin
          mem_d = (mem_q == `MSVC_MEM_A) ? `MSVC_MEM_A : mem_q - 2'h1;
        end
      end
      MODE_MOM_DED: begin
        if (closed[1]) begin
          if (!in_d_q) begin
            saved_d = mem_q;
          end
          in_d_d = 1'b1;
          mem_d = `MSVC_MEM_D;
        end else if (in_d_q) begin
          in_d_d = 1'b0;
          mem_d = saved_q;
        end else if (press[0]) begin
          mem_d = nxt;
        end
      end
      MODE_STAT_DUAL: begin
        mem_d = ms_cfg_i.mem_valid[dec] ? dec : `MSVC_MEM_A;
      end
      default: begin
        if (closed[1]) begin
          mem_d = `MSVC_MEM_D;
        end else begin
          mem_d = (closed[0] && ms_cfg_i.mem_valid[1]) ? 2'h1 : `MSVC_MEM_A;
        end
      end
    endcase
  end

  // Memory state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_q <= `MSVC_MEM_A;
      saved_q <= `MSVC_MEM_A;
      in_d_q <= 1'b0;
      started_q <= 1'b0;
    end else begin
      mem_q <= mem_d;
      saved_q <= saved_d;
      in_d_q <= in_d_d;
      started_q <= started_d;
    end
  end
  assign memory_o = mem_q;

  // ============================================================
  // Volume
  logic [4:0] vol_q, vol_d;
  logic up_q, dn_q, up_d, dn_d;
  logic [7:0] ag_q, ag_d;
  logic vc_busy;

  // Rocker used purely for memory select leaves volume to software
  assign vc_busy = rocker_ms;
  always_comb begin
    vol_d = vol_q;
    up_d = 1'b0;
    dn_d = 1'b0;
    ag_d = '0;
    if (vol_cfg_i.vol_from_sw) begin
      vol_d = vol_cfg_i.sw_volume;
    end else if (vol_cfg_i.digital_vol_en && !vc_busy) begin
      if (press[2] && vol_q != `MSVC_VOL_MAX) begin
        vol_d = vol_q + 5'h01;
        up_d = 1'b1;
      end else if (press[3] && vol_q != 5'h00) begin
        vol_d = vol_q - 5'h01;
        dn_d = 1'b1;
      end
    end else if (vol_cfg_i.analog_vol_en) begin
      // Square law stands in for a log taper; cheap and monotonic
      ag_d = vol_cfg_i.log_taper ? 8'((16'(analog_vol_i) * 16'(analog_vol_i)) >> 8)
                                 : analog_vol_i;
      vol_d = ag_d[7:3];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vol_q <= `MSVC_VOL_RST;
      up_q <= 1'b0;
      dn_q <= 1'b0;
      ag_q <= '0;
    end else begin
      vol_q <= vol_d;
      up_q <= up_d;
      dn_q <= dn_d;
      ag_q <= ag_d;
    end
  end
  assign volume_o = vol_q;
  assign vol_up_req_o = up_q;
  assign vol_down_req_o = dn_q;
  assign analog_gain_o = ag_q;

  // ============================================================
  // Trimmer assignment: each parameter picks a trimmer, top nibble is its level
  logic [3:0] pv_q [`MSVC_NUM_PARAM];
  generate
    for (gi = 0; gi < `MSVC_NUM_PARAM; gi++) begin : g_par
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pv_q[gi] <= '0;
        end else begin
          pv_q[gi] <= trim_raw_i[trim_sel_i[gi]][7:4];
        end
      end
      assign param_val_o[gi] = pv_q[gi];
    end
  endgenerate

  // ============================================================
  // Checks
  // Mode 2 with the jump switch closed
  sequence s_sec_close;
    (mode == MODE_MOM_DED) && closed[1];
  endsequence
  // Mode 2 with the jump switch open and no restore pending
  sequence s_ded_open;
    (mode == MODE_MOM_DED) && !closed[1] && !in_d_q;
  endsequence

  // Jump to D, save of the old memory and its restore
  AST_FORCE_D: assert property (@(posedge clk_i) disable iff (rst_i)
    s_sec_close |=> memory_o == `MSVC_MEM_D) else $error("not forced to D");
  AST_IGNORE_PRESS: assert property (@(posedge clk_i) disable iff (rst_i)
    s_sec_close ##0 (in_d_q && press[0]) |=> memory_o == `MSVC_MEM_D)
    else $error("press acted on while held in D");
  AST_SAVE: assert property (@(posedge clk_i) disable iff (rst_i)
    s_sec_close ##0 !in_d_q |=> saved_q == $past(mem_q))
    else $error("pre-jump memory not saved");
  AST_RESTORE: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == MODE_MOM_DED) && in_d_q && !closed[1] |=> memory_o == $past(saved_q))
    else $error("pre-jump memory not restored");

  // Cycling in mode 2 skips D and wraps from C
  AST_NO_D_CYCLE: assert property (@(posedge clk_i) disable iff (rst_i)
    s_ded_open |=> memory_o != `MSVC_MEM_D) else $error("D selected by cycling");
  AST_DED_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
    s_ded_open ##0 (press[0] && mem_q == 2'h2) |=> memory_o == `MSVC_MEM_A)
    else $error("mode 2 did not wrap past C");

  // Dual static decode
  AST_DECODE: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == MODE_STAT_DUAL) && ms_cfg_i.mem_valid[dec] |=> memory_o == $past(dec))
    else $error("static decode wrong");
  AST_INVALID_A: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == MODE_STAT_DUAL) && !ms_cfg_i.mem_valid[dec] |=> memory_o == `MSVC_MEM_A)
    else $error("invalid memory not replaced by A");

  // Static with dedicated D: second input wins, C is never reached
  AST_STAT_DED_D: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == MODE_STAT_DED) && closed[1] |=> memory_o == `MSVC_MEM_D)
    else $error("static dedicate did not select D");
  AST_STAT_DED_NO_C: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == MODE_STAT_DED) |=> memory_o != 2'h2)
    else $error("static dedicate selected C");

  // Single momentary advance and wrap
  AST_MOM_ADV: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == MODE_MOM_SINGLE) && press[0] && !rocker_ms && mem_q == `MSVC_MEM_A
    && ms_cfg_i.mem_valid[1] |=> memory_o == 2'h1) else $error("no advance to B");
  AST_WRAP: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == MODE_MOM_SINGLE) && press[0] && !rocker_ms && mem_q == `MSVC_MEM_D
    |=> memory_o == `MSVC_MEM_A) else $error("no wrap to A");

  // Volume steps, software override and exclusivity
  AST_VOL_UP: assert property (@(posedge clk_i) disable iff (rst_i)
    vol_up_req_o |-> volume_o == $past(volume_o) + 5'h01)
    else $error("volume up step wrong");
  AST_VOL_DOWN: assert property (@(posedge clk_i) disable iff (rst_i)
    vol_down_req_o |-> volume_o == $past(volume_o) - 5'h01)
    else $error("volume down step wrong");
  AST_SW_VOL: assert property (@(posedge clk_i) disable iff (rst_i)
    vol_cfg_i.vol_from_sw |=> volume_o == $past(vol_cfg_i.sw_volume))
    else $error("software volume not applied");
  AST_NO_PULSE: assert property (@(posedge clk_i) disable iff (rst_i)
    vol_cfg_i.vol_from_sw || rocker_ms |=> !vol_up_req_o && !vol_down_req_o)
    else $error("volume stepped while switch volume is off");
  AST_GAIN_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    !vol_cfg_i.analog_vol_en |=> analog_gain_o == 8'h00)
    else $error("analog gain driven with analog control off");

  // Trimmer routing, shown on the first parameter
  AST_PARAM: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> param_val_o[0] == $past(trim_raw_i[trim_sel_i[0]][7:4]))
    else $error("trimmer level not routed");

  // Conditioning: level held until a full period, presses only on edges
  AST_DEB_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (s2_q[1] != deb_q[1]) && (cnt_q[1] < deb_cycles_i) |=> deb_q[1] == $past(deb_q[1]))
    else $error("second input accepted before debounce period");
  AST_PRESS_EDGE: assert property (@(posedge clk_i) disable iff (rst_i)
    press[0] |-> closed[0] && !$past(closed[0])) else $error("press not on edge");
  AST_RESET_A: assert property (@(posedge clk_i)
    $past(rst_i) |-> memory_o == `MSVC_MEM_A && saved_q == `MSVC_MEM_A)
    else $error("memory not A after reset");
endmodule // msvc_ctrl

// File: hdl/msvc_defines.svh
// Constants for the memory-select and volume switch controller
// ============================================================
`ifndef MSVC_DEFINES_SVH
`define MSVC_DEFINES_SVH
`define MSVC_MEM_A 2'h0
`define MSVC_MEM_D 2'h3
`define MSVC_VOL_MAX 5'h1f
`define MSVC_VOL_RST 5'h10
`define MSVC_DEB_CYC 16'h03e8
`define MSVC_NUM_TRIM 4
`define MSVC_NUM_PARAM 19
`define MSVC_TRIM_LVLS 16
`endif

// File: hdl/msvc_pkg.sv
// Types shared by the memory-select and volume switch controller
package msvc_pkg;
  typedef enum logic [3:0] {
    MODE_MOM_SINGLE = 4'h1,
    MODE_MOM_DED = 4'h2,
    MODE_STAT_DUAL = 4'h4,
    MODE_STAT_DED = 4'h8
  } sw_mode_t;
  typedef struct packed {
    logic switch_type_setting; // 1 = static
    logic dedicate_setting;
    logic first_polarity_setting; // 1 = pullup
    logic second_polarity_setting;
    logic [3:0] mem_valid;
  } ms_cfg_t;
  typedef struct packed {
    logic digital_vol_en;
    logic analog_vol_en;
    logic vol_from_sw;
    logic rocker_ms_en;
    logic log_taper;
    logic [4:0] sw_volume;
  } vol_cfg_t;
endpackage

// File: verification/switch_model.sv
// Model of the user switches wired to the select and volume pins
module switch_model (
  // Commanded switch states, 1 = closed
  input wire logic closed1_i,
  input wire logic closed2_i,
  input wire logic up_i,
  input wire logic down_i,
  // Wiring per select input, 1 = switch to ground with pull-up
  input wire logic pol1_i,
  input wire logic pol2_i,
  // Pin levels
  output logic pin1_o,
  output logic pin2_o,
  output logic up_o,
  output logic down_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // A switch to ground pulls its pin low when closed, one to battery high
  assign pin1_o = closed1_i ^ pol1_i;
  assign pin2_o = closed2_i ^ pol2_i;
  // Volume buttons close to battery
  assign up_o = up_i;
  assign down_o = down_i;
endmodule // switch_model

// File: verification/tb.sv
// Self-checking bench for the memory-select and volume switch controller
`include "msvc_defines.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import msvc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic c1 = 1'b0, c2 = 1'b0, up = 1'b0, dn = 1'b0;
  logic p1, p2, vu, vd, vol_up_req_o, vol_down_req_o;
  ms_cfg_t ms_cfg = '{1'b0, 1'b0, 1'b0, 1'b0, 4'h7};
  vol_cfg_t vol_cfg = '0;
  logic [7:0] analog_vol = 8'h00;
  logic [7:0] analog_gain_o;
  logic [7:0] trim_raw [`MSVC_NUM_TRIM] = '{default: 8'h00};
  logic [1:0] trim_sel [`MSVC_NUM_PARAM] = '{default: 2'h0};
  logic [3:0] param_val_o [`MSVC_NUM_PARAM];
  logic [1:0] memory_o, prev_mem = 2'h0;
  logic [4:0] volume_o, prev_vol = 5'h10;
  logic [1:0] mem_q [$];
  logic [4:0] vol_q [$];
  logic [15:0] lfsr = 16'h0002;
  int n_errors = 0, n_checks = 0, n_up = 0, n_dn = 0;
  // ============================================================
  // Clock, far side and device
  always #5 clk_i = ~clk_i;
  switch_model u_switch_model (.closed1_i(c1), .closed2_i(c2), .up_i(up), .down_i(dn),
    .pol1_i(ms_cfg.first_polarity_setting), .pol2_i(ms_cfg.second_polarity_setting),
    .pin1_o(p1), .pin2_o(p2), .up_o(vu), .down_o(vd));
  msvc_ctrl u_msvc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .first_select_input_i(p1),
    .second_select_input_i(p2), .volume_up_input_i(vu), .volume_down_input_i(vd),
    .ms_cfg_i(ms_cfg), .vol_cfg_i(vol_cfg), .deb_cycles_i(16'h0002),
    .analog_vol_i(analog_vol), .trim_raw_i(trim_raw), .trim_sel_i(trim_sel),
    .memory_o(memory_o), .volume_o(volume_o), .analog_gain_o(analog_gain_o),
    .vol_up_req_o(vol_up_req_o), .vol_down_req_o(vol_down_req_o), .param_val_o(param_val_o));
  // ============================================================
  // Helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Move both select switches, noting the memory expected (negative: none)
  task automatic step(input logic a, input logic b, input int e);
    if (e >= 0) mem_q.push_back(e[1:0]);
    @(posedge clk_i);
    c1 <= a;
    c2 <= b;
    repeat (12) @(posedge clk_i);
  endtask
  task automatic press(input int e);
    step(1'b1, c2, e);
    step(1'b0, c2, -1);
  endtask
  task automatic vol(input logic u, input logic [4:0] e);
    vol_q.push_back(e);
    up <= u;
    dn <= ~u;
    repeat (12) @(posedge clk_i);
    up <= 1'b0;
    dn <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask
  // ============================================================
  // Watcher: every memory or volume output change takes the oldest note
  always @(posedge clk_i) begin
    if (!rst_i && memory_o !== prev_mem) begin
      if (mem_q.size() == 0) check("memory", memory_o, 8'hff);
      else check("memory", memory_o, mem_q.pop_front());
    end
    if (!rst_i && volume_o !== prev_vol) begin
      if (vol_q.size() == 0) check("volume", volume_o, 8'hff);
      else check("volume", volume_o, vol_q.pop_front());
    end
    if (vol_up_req_o === 1'b1) n_up++;
    if (vol_down_req_o === 1'b1) n_dn++;
    prev_mem <= memory_o;
    prev_vol <= volume_o;
  end
  // A hang counts as a mismatch
  initial begin
    repeat (90000) @(posedge clk_i);
    n_errors++;
    report_and_stop();
  end
  // ============================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check("memory reset", memory_o, 8'h00);
    check("volume reset", volume_o, 8'h10);
    press(1); press(2); press(0);
    ms_cfg.mem_valid <= 4'hf;
    press(1); press(2); press(3); press(0);
    $display("Test single momentary done");
    ms_cfg.dedicate_setting <= 1'b1;
    press(1);
    step(1'b0, 1'b1, 3);
    press(-1);
    step(1'b0, 1'b0, 1);
    press(2); press(0);
    $display("Test momentary with dedicated D done");
    ms_cfg <= '{1'b1, 1'b0, 1'b1, 1'b1, 4'hf};
    repeat (20) @(posedge clk_i);
    step(1'b1, 1'b0, 1); step(1'b1, 1'b1, 3);
    step(1'b0, 1'b1, 2); step(1'b0, 1'b0, 0);
    ms_cfg.mem_valid <= 4'h3;
    step(1'b0, 1'b1, -1); step(1'b0, 1'b0, -1);
    $display("Test dual static done");
    ms_cfg <= '{1'b1, 1'b1, 1'b1, 1'b1, 4'hf};
    repeat (20) @(posedge clk_i);
    step(1'b1, 1'b0, 1); step(1'b1, 1'b1, 3);
    step(1'b0, 1'b1, -1); step(1'b0, 1'b0, 0);
    $display("Test static with dedicated D done");
    vol_cfg <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 5'h00};
    vol(1'b1, 5'h11); vol(1'b0, 5'h10); vol(1'b0, 5'h0f);
    check("up pulses", n_up[7:0], 8'h01);
    check("down pulses", n_dn[7:0], 8'h02);
    $display("Test digital volume done");
    repeat (4) begin
      @(posedge clk_i);
      for (int i = 0; i < 4; i++) trim_raw[i] <= lfsr[15:8] ^ (8'h37 * i[7:0]);
      for (int k = 0; k < 19; k++) trim_sel[k] <= lfsr[k % 15 +: 2];
      analog_vol <= lfsr[7:0];
      lfsr = lfsr_next(lfsr);
      repeat (6) @(posedge clk_i);
      for (int k = 0; k < 19; k++)
        check("param", param_val_o[k], trim_raw[trim_sel[k]][7:4]);
    end
    $display("Test trimmers done");
    vol_q.push_back(5'h07);
    vol_cfg <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 5'h07};
    repeat (4) @(posedge clk_i);
    analog_vol <= 8'h80;
    vol_q.push_back(5'h10);
    vol_cfg <= '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 5'h00};
    repeat (4) @(posedge clk_i);
    #1 check("analog gain", analog_gain_o, 8'h80);
    @(posedge clk_i);
    vol_q.push_back(5'h08);
    vol_cfg <= '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 5'h00};
    repeat (4) @(posedge clk_i);
    #1 check("log gain", analog_gain_o, 8'h40);
    $display("Test analog and software volume done");
    check("memory notes left", mem_q.size(), 8'h00);
    check("volume notes left", vol_q.size(), 8'h00);
    report_and_stop();
  end
endmodule // tb
